// ===== hw/flash_erase_pkg.sv
// Constants and types for the serial flash erase and protection block.
// Assumes one system clock, a host-driven serial clock and mode 0 or 3.
// Overview of operation
// - Opcodes 20h, 52h, D8h erase a 4K, 32K or 64K block.
// - Erase and status-write commands need the write latch set beforehand.
// - Block erase takes opcode plus three address bytes; starts at select release.
// - Block erase ignores address bits below the block size.
// - Block erase aborts if address short or select released off a byte.
// - Block erase on protected memory is skipped; back to idle at release.
// - Aborted block erase clears the write latch.
// - Running erase reports busy; write latch cleared before the erase ends.
// - Opcodes 60h and C7h both erase the whole array, no address.
// - Chip erase skipped on short opcode, unaligned release or protection.
// - Chip erase clears the write latch on unaligned release or protection.
// - Opcode 06h sets the write latch at aligned release of a whole opcode.
// - Opcode 04h clears the write latch at aligned release of a whole opcode.
// - Protection bits change only through the status-write command.
// - Invert clear: range 000 none; large units 001-011 protect upper eighth, quarter, half.
// - With bottom select, large units 001-011 protect the lowest eighth, quarter, half.
// - Whole array protected for large units with bit2, or small units with 111.
// - Small units, top: codes protect top 4K, 8K, 16K and 32K.
// - Small units, bottom: codes protect bottom 4K, 8K, 16K and 32K.
// - Invert set protects exactly the complement of the invert-clear region.
// - Status reads are answered at any time, even while busy.
// - Lock pin low refuses any change to protection bits.
package flash_erase_pkg;
  localparam logic [7:0]  OP_BLOCK4     = 8'h20;
  localparam logic [7:0]  OP_BLOCK32    = 8'h52;
  localparam logic [7:0]  OP_BLOCK64    = 8'hd8;
  localparam logic [7:0]  OP_CHIP_A     = 8'h60;
  localparam logic [7:0]  OP_CHIP_B     = 8'hc7;
  localparam logic [7:0]  OP_WRITE_EN   = 8'h06;
  localparam logic [7:0]  OP_WRITE_DIS  = 8'h04;
  localparam logic [7:0]  OP_STATUS_RD  = 8'h05;
  localparam logic [7:0]  OP_STATUS_WR  = 8'h01;
  localparam logic [19:0] ARRAY_BYTES   = 20'h80000;
  localparam logic [19:0] SIZE_4K       = 20'h01000;
  localparam logic [19:0] SIZE_32K      = 20'h08000;
  localparam logic [19:0] SIZE_64K      = 20'h10000;
  localparam logic [2:0]  BYTES_FULL    = 3'h4;   // Opcode plus three address bytes
  localparam logic [2:0]  SYNC_IDLE     = 3'h7;
  localparam int          ST2_INVERT    = 6;      // Invert bit in second status byte
  localparam int          BLOCK_CYCLES  = 2000;
  localparam int          CHIP_CYCLES   = 8000;

  typedef struct packed {
    logic protect_invert;
    logic small_unit_select;
    logic top_bottom_select;
    logic range_select_bit2;
    logic range_select_bit1;
    logic range_select_bit0;
  } prot_type;
  localparam prot_type PROT_RESET = 6'h00;

  typedef enum logic {ST_IDLE, ST_ERASE} core_state_type;

  typedef struct packed {
    logic [19:0] base;
    logic [19:0] len;
  } erase_req_type;

  typedef struct packed {
    logic [2:0]  bits;
    logic [2:0]  bytes;
    logic [6:0]  shift;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  stat_meta;
    logic [7:0]  stat_sync;
  } link_state_type;

  typedef struct packed {
    core_state_type state;
    logic [2:0]     cs_pipe;
    logic           cs_lvl;
    logic [2:0]     wp_pipe;
    logic           wp_lvl;
    logic           write_latch_flag;
    prot_type       prot;
    logic [31:0]    count;
    erase_req_type  req;
    logic           start;
    logic           done;
  } core_state_full_type;
endpackage : flash_erase_pkg

// ===== hw/flash_erase_ctrl.sv
// Command logic for erase, write latch and protection of a serial flash.
// Assumes the host idles the serial clock around select edges for a few system clocks.
module flash_erase_ctrl
  import flash_erase_pkg::*;
#(
  parameter int unsigned BLOCK_ERASE_CYCLES = BLOCK_CYCLES,
  parameter int unsigned CHIP_ERASE_CYCLES  = CHIP_CYCLES
) (
  input  wire logic          clk_in,                // System clock
  input  wire logic          rst_in,                // Async reset, high
  input  wire logic          ce_in,                 // Clock enable, core side
  input  wire logic          link_clk_in,           // Serial clock from host
  input  wire logic          cs_n_in,               // Chip select, low active
  input  wire logic          mosi_in,               // Serial data in
  input  wire logic          wp_n_in,               // Lock pin, low locks
  output logic               miso_out,              // Serial data out
  output logic               miso_oe_out,           // Drive enable of data out
  output logic               busy_flag_out,         // Erase in progress
  output logic               write_latch_flag_out,  // Write latch state
  output prot_type           prot_out,              // Protection bits
  output logic               erase_start_out,       // Erase begins, pulse
  output logic               erase_done_out,        // Erase ends, pulse
  output erase_req_type      erase_req_out          // Region being erased
);

  link_state_type      lnk_q, lnk_d;
  core_state_full_type c_q, c_d;
  logic                fresh_q;
  logic                miso_q;
  logic                frame_end;
  logic                have_op;
  logic                aligned;
  logic                is_blk;
  logic                is_chip;
  logic                hit;
  logic [19:0]         blen;
  logic [19:0]         elo;
  logic [19:0]         elen;

  // Region test against protection bits; invert protects the complement
  function automatic logic prot_hit(prot_type p, logic [19:0] lo, logic [19:0] len);
    logic [2:0]  bp;
    logic [19:0] sz;
    logic [19:0] rlo;
    logic [19:0] rend;
    logic [19:0] eend;
    bp = {p.range_select_bit2, p.range_select_bit1, p.range_select_bit0};
    if (bp == 3'h0) begin
      sz = 20'h0;
    end else if (p.small_unit_select) begin
      if (bp == 3'h7) begin
        sz = ARRAY_BYTES;
      end else if (bp[2]) begin
        sz = SIZE_32K;
      end else begin
        sz = SIZE_4K << (bp[1:0] - 2'h1);
      end
    end else if (bp[2]) begin
      sz = ARRAY_BYTES;
    end else begin
      sz = SIZE_64K << (bp[1:0] - 2'h1);
    end
    rlo  = p.top_bottom_select ? 20'h0 : ARRAY_BYTES - sz;
    rend = p.top_bottom_select ? sz : ARRAY_BYTES;
    eend = lo + len;
    if (p.protect_invert) begin
      return !(lo >= rlo && eend <= rend);
    end
    return (lo < rend) && (rlo < eend);
  endfunction

  // New frame marker; select high arms a restart of the bit counters
  always_ff @(posedge link_clk_in or posedge cs_n_in or posedge rst_in) begin
    if (rst_in) begin
      fresh_q <= 1'b1;
    end else if (cs_n_in) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // Link side shifter; words stay frozen after select rises since the clock stops
  always_comb begin
    lnk_d = lnk_q;
    if (fresh_q) begin
      lnk_d.bits  = 3'h0;
      lnk_d.bytes = 3'h0;
    end
    if (lnk_d.bits == 3'h7) begin
      if (lnk_d.bytes == 3'h0) begin
        lnk_d.opcode = {lnk_d.shift, mosi_in};
      end else if (lnk_d.bytes != BYTES_FULL) begin
        lnk_d.addr = {lnk_d.addr[15:0], lnk_d.shift, mosi_in};
      end
      if (lnk_d.bytes != BYTES_FULL) begin
        lnk_d.bytes = lnk_d.bytes + 3'h1;
      end
    end
    lnk_d.shift     = {lnk_d.shift[5:0], mosi_in};
    lnk_d.bits      = lnk_d.bits + 3'h1;
    lnk_d.stat_meta = {2'b00, c_q.prot.top_bottom_select, c_q.prot.range_select_bit2,
                       c_q.prot.range_select_bit1, c_q.prot.range_select_bit0,
                       c_q.write_latch_flag, c_q.state == ST_ERASE};
    lnk_d.stat_sync = lnk_q.stat_meta;
  end

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // Status byte out on falling edges, MSB first, repeating while select stays low
  always_ff @(negedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= lnk_q.stat_sync[~lnk_q.bits];
    end
  end

  assign miso_out    = miso_q;
  assign miso_oe_out = !cs_n_in && !fresh_q && lnk_q.bytes != 3'h0 && lnk_q.opcode == OP_STATUS_RD;

  // Frame decode from the frozen link words
  always_comb begin
    frame_end = ce_in && c_q.cs_pipe[1] && c_q.cs_pipe[2] && !c_q.cs_lvl;
    have_op   = lnk_q.bytes != 3'h0;
    aligned   = lnk_q.bits == 3'h0;
    is_chip   = have_op && (lnk_q.opcode == OP_CHIP_A || lnk_q.opcode == OP_CHIP_B);
    is_blk    = have_op;
    unique case (lnk_q.opcode)
      OP_BLOCK4:  blen = SIZE_4K;
      OP_BLOCK32: blen = SIZE_32K;
      OP_BLOCK64: blen = SIZE_64K;
      default: begin
        blen   = 20'h0;
        is_blk = 1'b0;
      end
    endcase
    elo  = is_chip ? 20'h0 : {1'b0, lnk_q.addr[18:0]} & ~(blen - 20'h1);
    elen = is_chip ? ARRAY_BYTES : blen;
    hit  = prot_hit(c_q.prot, elo, elen);
  end

  // Core sequencer; select and lock pin pass three flops and a match filter
  always_comb begin
    c_d       = c_q;
    c_d.start = 1'b0;
    c_d.done  = 1'b0;
    c_d.cs_pipe = {c_q.cs_pipe[1:0], cs_n_in};
    c_d.wp_pipe = {c_q.wp_pipe[1:0], wp_n_in};
    if (c_q.cs_pipe[1] == c_q.cs_pipe[2]) begin
      c_d.cs_lvl = c_q.cs_pipe[2];
    end
    if (c_q.wp_pipe[1] == c_q.wp_pipe[2]) begin
      c_d.wp_lvl = c_q.wp_pipe[2];
    end
    unique case (c_q.state)
      ST_IDLE: begin
        if (frame_end && have_op && aligned && lnk_q.opcode == OP_WRITE_EN) begin
          c_d.write_latch_flag = 1'b1;
        end else if (frame_end && have_op && aligned && lnk_q.opcode == OP_WRITE_DIS) begin
          c_d.write_latch_flag = 1'b0;
        end else if (frame_end && (is_blk || is_chip) && c_q.write_latch_flag) begin
          c_d.write_latch_flag = 1'b0;
          if (aligned && !hit && (is_chip || lnk_q.bytes == BYTES_FULL)) begin
            c_d.state    = ST_ERASE;
            c_d.start    = 1'b1;
            c_d.req.base = elo;
            c_d.req.len  = elen;
            c_d.count    = is_chip ? 32'(CHIP_ERASE_CYCLES) : 32'(BLOCK_ERASE_CYCLES);
          end
        end else if (frame_end && have_op && c_q.write_latch_flag && lnk_q.opcode == OP_STATUS_WR) begin
          c_d.write_latch_flag = 1'b0;
          if (aligned && lnk_q.bytes >= 3'h2 && c_q.wp_lvl) begin
            unique case (lnk_q.bytes)
              3'h2: c_d.prot[4:0] = lnk_q.addr[6:2];
              3'h3: c_d.prot = {lnk_q.addr[ST2_INVERT], lnk_q.addr[14:10]};
              default: c_d.prot = {lnk_q.addr[8 + ST2_INVERT], lnk_q.addr[22:18]};
            endcase
          end
        end
      end
      ST_ERASE: begin
        c_d.count = c_q.count - 32'h1;
        if (c_q.count <= 32'h1) begin
          c_d.state = ST_IDLE;
          c_d.done  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      c_q         <= '0;
      c_q.state   <= ST_IDLE;
      c_q.cs_pipe <= SYNC_IDLE;
      c_q.cs_lvl  <= 1'b1;
      c_q.wp_pipe <= SYNC_IDLE;
      c_q.wp_lvl  <= 1'b1;
      c_q.prot    <= PROT_RESET;
    end else if (ce_in) begin
      c_q <= c_d;
    end
  end

  // Outputs straight from core flops
  assign busy_flag_out        = c_q.state == ST_ERASE;
  assign write_latch_flag_out = c_q.write_latch_flag;
  assign prot_out             = c_q.prot;
  assign erase_start_out      = c_q.start;
  assign erase_done_out       = c_q.done;
  assign erase_req_out        = c_q.req;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_erase_frame;
    frame_end && c_q.state == ST_IDLE && (is_blk || is_chip) && c_q.write_latch_flag;
  endsequence

  sequence s_enable_frame;
    frame_end && c_q.state == ST_IDLE && have_op && aligned && lnk_q.opcode == OP_WRITE_EN;
  endsequence

  // Rising edge only, so a start pulse held by a low clock enable does not misfire
  AST_START_NEEDS_LATCH: assert property ($rose(erase_start_out) |-> $past(c_q.write_latch_flag))
    else $error("erase started without write latch");
  AST_START_BUSY: assert property (erase_start_out |-> busy_flag_out && !write_latch_flag_out)
    else $error("erase start without busy or with latch set");
  AST_ABORT_CLEARS: assert property (s_erase_frame ##0 !aligned |=> !write_latch_flag_out && !busy_flag_out)
    else $error("unaligned erase did not abort");
  AST_PROT_SKIP: assert property (s_erase_frame ##0 hit |=> !erase_start_out && !write_latch_flag_out)
    else $error("protected erase was started");
  AST_SHORT_ADDR: assert property (s_erase_frame ##0 (is_blk && lnk_q.bytes != BYTES_FULL) |=> !busy_flag_out)
    else $error("block erase with short address started");
  AST_BLOCK_BASE: assert property (erase_start_out && erase_req_out.len != ARRAY_BYTES
                                   |-> (erase_req_out.base & (erase_req_out.len - 20'h1)) == 20'h0)
    else $error("block base not aligned to block size");
  AST_LATCH_SET: assert property (s_enable_frame |=> write_latch_flag_out ##1 write_latch_flag_out || $past(frame_end))
    else $error("write enable did not set latch");
  AST_LATCH_CLEAR: assert property (frame_end && c_q.state == ST_IDLE && have_op && aligned
                                    && lnk_q.opcode == OP_WRITE_DIS |=> !write_latch_flag_out)
    else $error("write disable did not clear latch");
  AST_PROT_STABLE: assert property (!frame_end |=> $stable(prot_out))
    else $error("protection changed outside a status write");
  AST_LOCKED: assert property (frame_end && !c_q.wp_lvl |=> $stable(prot_out))
    else $error("protection changed while locked");
  AST_BUSY_END: assert property ($fell(busy_flag_out) |-> erase_done_out && !write_latch_flag_out)
    else $error("busy ended without done pulse");
endmodule // flash_erase_ctrl

// ===== test/spi_host_model.sv
// Behavioural serial host that drives select, serial clock and data.
// Assumes the bench calls frame() from its main process, one frame at a time.
module spi_host_model (
  output logic      link_clk_out,  // Serial clock, stands low between frames
  output logic      cs_n_out,      // Chip select, low active
  output logic      mosi_out,      // Serial data to device
  input  wire logic miso_in,       // Serial data from device
  input  wire logic miso_oe_in     // Device drives data out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rx;  // Bits captured while device drives

  initial begin
    link_clk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    rx = 16'h0000;
  end

  // One frame of n bits, MSB first; odd offsets keep edges off the system clock
  task automatic frame(input logic [39:0] d, input int n);
    cs_n_out = 1'b0;
    #43;
    for (int i = 0; i < n; i++) begin
      mosi_out = d[39-i];
      #80 link_clk_out = 1'b1;
      if (miso_oe_in === 1'b1) rx = {rx[14:0], miso_in};
      #80 link_clk_out = 1'b0;
    end
    #37 cs_n_out = 1'b1;
    mosi_out = ~mosi_out; // Released line shows no stale value
  endtask
endmodule // spi_host_model

// ===== test/test_spi_flash_erase_and_protection.sv
// Self-checking bench for the erase and protection command logic.
// Assumes the host model is the only driver of the serial pins.
module test_spi_flash_erase_and_protection;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_erase_pkg::*;
  localparam int BLK = 8;
  localparam int CHP = 400;  // Long enough to read status mid-erase
  logic          clk_in, rst_in, ce_in, wp_n_in, link_clk, cs_n, mosi, miso, miso_oe;
  logic          busy_flag_out, write_latch_flag_out, erase_start_out, erase_done_out;
  prot_type      prot_out;
  erase_req_type erase_req_out;
  erase_req_type notes[$];
  int            err_count, num_checks, seed, cyc;
  logic [19:0]   run_len, lens[3], ra[5], ok[5], base;
  logic [7:0]    ops[3];
  logic [15:0]   sw[5];
  prot_type      pe[5];
  logic [31:0]   a;

  flash_erase_ctrl #(.BLOCK_ERASE_CYCLES(BLK), .CHIP_ERASE_CYCLES(CHP)) u_flash_erase_ctrl (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .link_clk_in(link_clk), .cs_n_in(cs_n),
    .mosi_in(mosi), .wp_n_in(wp_n_in), .miso_out(miso), .miso_oe_out(miso_oe),
    .busy_flag_out(busy_flag_out), .write_latch_flag_out(write_latch_flag_out), .prot_out(prot_out),
    .erase_start_out(erase_start_out), .erase_done_out(erase_done_out), .erase_req_out(erase_req_out));
  spi_host_model u_spi_host_model (.link_clk_out(link_clk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso), .miso_oe_in(miso_oe));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Poll busy rather than wait the worst case
  task automatic wait_idle;
    repeat (8) @(negedge clk_in);
    for (int i = 0; i < 1000 && busy_flag_out !== 1'b0; i++) @(negedge clk_in);
    check(busy_flag_out, 1'b0);
  endtask

  task automatic cmd(input logic [39:0] d, input int n, input bit ex, input logic [19:0] b,
                     input logic [19:0] l, input logic wl);
    if (ex) notes.push_back(erase_req_type'({b, l}));
    u_spi_host_model.frame(d, n);
    wait_idle();
    check(notes.size(), 0);
    check(write_latch_flag_out, wl);
  endtask

  task automatic wren;
    cmd({OP_WRITE_EN, 32'h0}, 8, 0, 20'h0, 20'h0, 1'b1);
  endtask

  // Watch start and done pulses against the oldest note
  always @(posedge clk_in) begin
    if (rst_in === 1'b0) begin
      if (erase_start_out === 1'b1) begin
        cyc = 0;
        check(write_latch_flag_out, 1'b0);
        if (notes.size() == 0) check(1'b1, 1'b0);
        else begin
          run_len = notes[0].len;
          check(erase_req_out, notes.pop_front());
        end
      end
      if (busy_flag_out === 1'b1) cyc++;
      if (erase_done_out === 1'b1) check(cyc, (run_len == ARRAY_BYTES) ? CHP : BLK);
    end
  end

  // About four times the expected length of all scenarios
  initial begin
    #700us;
    err_count++;
    final_report();
  end

  initial begin
    seed = 6; rst_in = 1'b1; ce_in = 1'b1; wp_n_in = 1'b1; err_count = 0; num_checks = 0;
    cyc = 0; run_len = 20'h0;
    ops = '{OP_BLOCK4, OP_BLOCK32, OP_BLOCK64}; lens = '{SIZE_4K, SIZE_32K, SIZE_64K};
    sw = '{16'h0400, 16'h2800, 16'h6440, 16'h4c00, 16'h7800};
    pe = '{6'h01, 6'h0a, 6'h39, 6'h13, 6'h1e};
    ra = '{20'h70000, 20'h1f000, 20'h01000, 20'h7c000, 20'h07000};
    ok = '{20'h6f000, 20'h20000, 20'h00000, 20'h7b000, 20'h08000};
    repeat (8) @(posedge clk_in);
    @(negedge clk_in) rst_in = 1'b0;
    check({prot_out, write_latch_flag_out, busy_flag_out}, {PROT_RESET, 2'b00});
    repeat (8) @(negedge clk_in);
    cmd({OP_BLOCK4, 32'h0}, 32, 0, 20'h0, 20'h0, 1'b0);
    cmd({OP_WRITE_EN, 32'h0}, 7, 0, 20'h0, 20'h0, 1'b0);
    cmd({OP_WRITE_EN, 32'h0}, 16, 0, 20'h0, 20'h0, 1'b1);
    cmd({OP_WRITE_DIS, 32'h0}, 9, 0, 20'h0, 20'h0, 1'b1);
    cmd({OP_WRITE_DIS, 32'h0}, 16, 0, 20'h0, 20'h0, 1'b0);
    // Clock enable low holds the core: the latch must wait until it returns
    u_spi_host_model.frame({OP_WRITE_EN, 32'h0}, 8);
    @(negedge clk_in) ce_in = 1'b0;
    repeat (20) @(negedge clk_in);
    check(write_latch_flag_out, 1'b0);
    @(negedge clk_in) ce_in = 1'b1;
    wait_idle();
    check(write_latch_flag_out, 1'b1);
    $display("latch test done");
    for (int k = 0; k < 2; k++) begin
      wren();
      cmd({OP_BLOCK4, 32'h0}, (k == 0) ? 24 : 33, 0, 20'h0, 20'h0, 1'b0);
    end
    $display("abort test done");
    // Random addresses, low bits must not matter; last one carries a trailing byte
    for (int k = 0; k < 3; k++) begin
      a = $random(seed);
      base = a[19:0] & ~(lens[k] - 20'h1) & (ARRAY_BYTES - 20'h1);
      wren();
      cmd({ops[k], a[23:0], 8'ha5}, (k == 2) ? 40 : 32, 1, base, lens[k], 1'b0);
    end
    $display("block erase test done");
    wren();
    notes.push_back(erase_req_type'({20'h0, ARRAY_BYTES}));
    u_spi_host_model.frame({OP_CHIP_B, 32'h0}, 8);
    repeat (8) @(negedge clk_in);
    u_spi_host_model.frame({OP_STATUS_RD, 32'h0}, 16);
    check(u_spi_host_model.rx[7:0], 8'h01);
    wait_idle();
    wren();
    cmd({OP_CHIP_A, 32'h0}, 16, 1, 20'h0, ARRAY_BYTES, 1'b0);
    wren();
    cmd({OP_CHIP_A, 32'h0}, 10, 0, 20'h0, 20'h0, 1'b0);
    $display("chip erase test done");
    for (int k = 0; k < 5; k++) begin
      wren();
      cmd({OP_STATUS_WR, sw[k], 16'h0}, 24, 0, 20'h0, 20'h0, 1'b0);
      check(prot_out, pe[k]);
      wren();
      cmd({OP_BLOCK4, 4'h0, ra[k], 8'h0}, 32, 0, 20'h0, 20'h0, 1'b0);
      wren();
      cmd({OP_BLOCK4, 4'h0, ok[k], 8'h0}, 32, 1, ok[k], SIZE_4K, 1'b0);
    end
    // Large units with range bit 2 set protect the whole array
    wren();
    cmd({OP_STATUS_WR, 16'h1000, 16'h0}, 24, 0, 20'h0, 20'h0, 1'b0);
    check(prot_out, 6'h04);
    wren();
    cmd({OP_CHIP_B, 32'h0}, 8, 0, 20'h0, 20'h0, 1'b0);
    @(negedge clk_in) wp_n_in = 1'b0;
    wren();
    cmd({OP_STATUS_WR, 32'h0}, 24, 0, 20'h0, 20'h0, 1'b0);
    check(prot_out, 6'h04);
    @(negedge clk_in) wp_n_in = 1'b1;
    $display("protection test done");
    final_report();
  end
endmodule // test_spi_flash_erase_and_protection
